// ==== tcc_consts.vh ====
// constants for the temperature compensated correction controller
`ifndef TCC_CONSTS_VH
`define TCC_CONSTS_VH
`define TCC_CLK_HZ 1000000
`define TCC_CNT_W 8
`define TCC_CNT_MAX 8'hFF
`define TCC_PWM_W 8
`define TCC_TEMP_W 8
`define TCC_IDX_W 4
`define TCC_FRAC_W 4
`define TCC_TAB_DEPTH 16
`define TCC_PRECHARGE_CYC 8'h40
`define TCC_PWM_REPEAT 8'h04
`endif

// ==== tcc_pwm.v ====
// one pulse-width correction output
`timescale 1ns/100ps
module tcc_pwm #(
    parameter WIDTH = 8
) (
    clk,
    reset_n,
    phase,
    duty,
    pwm_out
);
    input wire clk;
    input wire reset_n;
    input wire [WIDTH-1:0] phase;
    input wire [WIDTH-1:0] duty;
    output reg pwm_out;

    // duty granularity is one counter step
    always @(posedge clk) begin
        if (!reset_n) begin
            pwm_out <= 1'b0;
        end else begin
            pwm_out <= (phase < duty);
        end
    end
endmodule // tcc_pwm

// ==== tcc_ctrl.v ====
// temperature ramp converter, table interpolation and two pwm outputs
// Function
// [R1] everything runs from the single 1 MHz clock clk
// [R2] discharge pin asserted at start instant; counter starts same edge
// [R3] comparator trip latches flag and captures count as temperature
// [R4] each output toggles between two levels within a fixed period
// [R5] duty granularity equals one clock step of the pwm counter
// [R6] span on first pwm output, offset on second, independent
// [R7] init, measure and address, drive outputs, repeat forever
// [R8] correction table held in nonvolatile memory, read at run time; here volatile registers written through tab_we
// [R9] calibration station records values at two or three temperatures
// [R10] corrections between table points by linear interpolation
// [R11] external programmer writes the table before normal operation
// [R12] no trip by counter maximum saturates, end-of-table values used
`timescale 1ns/100ps
`include "tcc_consts.vh"
module tcc_ctrl #(
    parameter CNT_W = `TCC_CNT_W,
    parameter DEPTH = `TCC_TAB_DEPTH
) (
    clk,
    reset_n,
    comp_in,
    tab_we,
    tab_addr,
    tab_span,
    tab_offset,
    discharge_out,
    pwm_span,
    pwm_offset,
    temp_valid,
    temp_value,
    temp_overrange
);
    input wire clk;
    input wire reset_n;
    input wire comp_in;
    input wire tab_we;
    input wire [`TCC_IDX_W-1:0] tab_addr;
    input wire [`TCC_PWM_W-1:0] tab_span;
    input wire [`TCC_PWM_W-1:0] tab_offset;
    output reg discharge_out;
    output wire pwm_span;
    output wire pwm_offset;
    output reg temp_valid;
    output reg [CNT_W-1:0] temp_value;
    output reg temp_overrange;

    localparam [2:0] ST_INIT = 3'd0;
    localparam [2:0] ST_CHARGE = 3'd1;
    localparam [2:0] ST_RAMP = 3'd2;
    localparam [2:0] ST_LOOKUP = 3'd3;
    localparam [2:0] ST_DRIVE = 3'd4;

    ////////////////////////////////////////////////////////////////////
    // correction table, nonvolatile in the real part
    // [R8] table storage
    reg [`TCC_PWM_W-1:0] span_mem [0:DEPTH-1];
    reg [`TCC_PWM_W-1:0] ofs_mem [0:DEPTH-1];
    // [R11] programmer write port
    always @(posedge clk) begin
        if (tab_we) begin
            span_mem[tab_addr] <= tab_span;
            ofs_mem[tab_addr] <= tab_offset;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // comparator synchroniser, comparator is asynchronous to clk
    reg comp_s1;
    reg comp_s2;
    always @(posedge clk) begin
        if (!reset_n) begin
            comp_s1 <= 1'b0;
            comp_s2 <= 1'b0;
        end else begin
            comp_s1 <= comp_in;
            comp_s2 <= comp_s1;
        end
    end

    // linear blend of two table points, frac in sixteenths
    function [`TCC_PWM_W-1:0] lerp;
        input [`TCC_PWM_W-1:0] a;
        input [`TCC_PWM_W-1:0] b;
        input [`TCC_FRAC_W-1:0] f;
        reg [`TCC_PWM_W+`TCC_FRAC_W:0] acc;
        begin
            acc = {1'b0, a, {`TCC_FRAC_W{1'b0}}}
                - {{(`TCC_FRAC_W+1){1'b0}}, a} * f
                + {{(`TCC_FRAC_W+1){1'b0}}, b} * f;
            lerp = acc[`TCC_PWM_W+`TCC_FRAC_W-1:`TCC_FRAC_W];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // timing notes
    // all counts are cycles of clk; no second clock and no crystal input
    // one pass: precharge, ramp of at most 256 cycles, one lookup cycle,
    // then drive until the fourth pwm phase wrap (the first period partial) before the next measurement
    // the comparator is resynchronised, so a trip is seen two cycles late;
    // the captured count carries that fixed offset, which calibration
    // absorbs together with the ramp slope
    // pwm runs on during measurement, so the outputs never stall
    // limitation: a table write in the lookup cycle may read old data
    // trade-off: 16 buckets keep the table small; interpolation in the
    // low four count bits recovers the lost resolution
    //

    ////////////////////////////////////////////////////////////////////
    // main sequence
    reg [2:0] state;
    reg [CNT_W-1:0] count;
    reg [`TCC_PWM_W-1:0] phase;
    reg [`TCC_PWM_W-1:0] duty_span;
    reg [`TCC_PWM_W-1:0] duty_ofs;
    reg [7:0] periods;
    wire [`TCC_IDX_W-1:0] idx;
    wire [`TCC_IDX_W-1:0] idx_next;
    wire [`TCC_FRAC_W-1:0] frac;
    assign idx = temp_value[CNT_W-1:CNT_W-`TCC_IDX_W];
    assign frac = temp_value[`TCC_FRAC_W-1:0];
    // [R12] end of table holds last entry
    assign idx_next = (idx == DEPTH - 1) ? idx : idx + 1'b1;

    // [R1] single clock domain
    always @(posedge clk) begin
        if (!reset_n) begin
            state <= ST_INIT;
            count <= {CNT_W{1'b0}};
            phase <= {`TCC_PWM_W{1'b0}};
            duty_span <= {`TCC_PWM_W{1'b0}};
            duty_ofs <= {`TCC_PWM_W{1'b0}};
            periods <= 8'h00;
            discharge_out <= 1'b0;
            temp_valid <= 1'b0;
            temp_value <= {CNT_W{1'b0}};
            temp_overrange <= 1'b0;
        end else begin
            // [R4] free running pwm period
            phase <= phase + 1'b1;
            case (state)
                // [R7] initialise variables
                ST_INIT: begin
                    count <= {CNT_W{1'b0}};
                    periods <= 8'h00;
                    discharge_out <= 1'b0;
                    state <= ST_CHARGE;
                end
                // capacitor recharges while pin released
                ST_CHARGE: begin
                    count <= count + 1'b1;
                    if (count == `TCC_PRECHARGE_CYC) begin
                        count <= {CNT_W{1'b0}};
                        // [R2] start discharge and count
                        discharge_out <= 1'b1;
                        temp_valid <= 1'b0;
                        state <= ST_RAMP;
                    end
                end
                ST_RAMP: begin
                    // [R3] trip latches flag and value
                    if (comp_s2) begin
                        temp_value <= count;
                        temp_valid <= 1'b1;
                        temp_overrange <= 1'b0;
                        discharge_out <= 1'b0;
                        state <= ST_LOOKUP;
                    // [R12] saturate on no trip
                    end else if (count == `TCC_CNT_MAX) begin
                        temp_value <= `TCC_CNT_MAX;
                        temp_valid <= 1'b1;
                        temp_overrange <= 1'b1;
                        discharge_out <= 1'b0;
                        state <= ST_LOOKUP;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                // [R10] interpolate between points
                ST_LOOKUP: begin
                    duty_span <= lerp(span_mem[idx], span_mem[idx_next],
                        frac);
                    duty_ofs <= lerp(ofs_mem[idx], ofs_mem[idx_next], frac);
                    periods <= 8'h00;
                    state <= ST_DRIVE;
                end
                // [R7] drive outputs, then measure again
                ST_DRIVE: begin
                    if (phase == `TCC_CNT_MAX) begin
                        periods <= periods + 1'b1;
                        if (periods == `TCC_PWM_REPEAT - 1) begin
                            count <= {CNT_W{1'b0}};
                            state <= ST_CHARGE;
                        end
                    end
                end
                default: begin
                    state <= ST_INIT;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // [R6] span first, offset second
    tcc_pwm #(.WIDTH(`TCC_PWM_W)) u_pwm_span (
        .clk(clk),
        .reset_n(reset_n),
        .phase(phase),
        .duty(duty_span),
        .pwm_out(pwm_span)
    );
    // [R5] one step resolution
    tcc_pwm #(.WIDTH(`TCC_PWM_W)) u_pwm_offset (
        .clk(clk),
        .reset_n(reset_n),
        .phase(phase),
        .duty(duty_ofs),
        .pwm_out(pwm_offset)
    );
endmodule // tcc_ctrl

// ==== tcc_ctrl_properties.sv ====
// port checker for the correction controller
`timescale 1ns/100ps
module tcc_ctrl_properties #(
    parameter CNT_W = 8
) (
    input wire clk,
    input wire reset_n,
    input wire comp_in,
    input wire discharge_out,
    input wire temp_valid,
    input wire [CNT_W-1:0] temp_value,
    input wire temp_overrange
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    AST_TRIP_ENDS_RAMP: assert property (discharge_out && $rose(comp_in)
        |-> ##[1:3] $fell(discharge_out)) else $error("ramp not ended");
    AST_VALID_AT_END: assert property ($fell(discharge_out)
        |-> temp_valid) else $error("no valid at ramp end");
    AST_VALID_TO_START: assert property ($fell(temp_valid)
        |-> $rose(discharge_out)) else $error("valid dropped early");
    AST_VALUE_HELD: assert property (temp_valid && $past(temp_valid)
        |-> $stable(temp_value)) else $error("value moved");
    AST_SATURATED: assert property (temp_valid && temp_overrange
        |-> temp_value == 8'hFF) else $error("not saturated");
    AST_OVR_ONLY_FULL: assert property (temp_valid && temp_value != 8'hFF
        |-> !temp_overrange) else $error("false overrange");
    AST_MEASURE_EXCL: assert property (discharge_out
        |-> !temp_valid) else $error("valid during ramp");
    AST_RAMP_BOUND: assert property ($rose(discharge_out)
        |-> ##[1:260] !discharge_out) else $error("ramp too long");
endmodule // tcc_ctrl_properties
bind tcc_ctrl tcc_ctrl_properties #(.CNT_W(CNT_W)) chk_u (.clk(clk),
    .reset_n(reset_n), .comp_in(comp_in), .discharge_out(discharge_out),
    .temp_valid(temp_valid), .temp_value(temp_value),
    .temp_overrange(temp_overrange));

// ==== tcc_analog_model.sv ====
// comparator and timing capacitor seen by the controller
`timescale 1ns/100ps
module tcc_analog_model (
    input wire clk,
    input wire discharge_out,
    input wire [8:0] trip_cyc,
    output logic comp_in
);
    logic [8:0] cnt;
    // trip after ramp time; beyond 255 never trips
    always @(posedge clk) begin
        if (!discharge_out) begin
            cnt <= 9'h000;
            comp_in <= 1'b0;
        end else begin
            cnt <= cnt + 9'h001;
            if (cnt == trip_cyc) comp_in <= 1'b1;
        end
    end
endmodule // tcc_analog_model

// ==== tcc_ctrl_tb_top.sv ====
// self-checking bench for the correction controller
`timescale 1ns/100ps
module tcc_ctrl_tb_top;
    logic clk, reset_n, tab_we, comp_in, discharge_out, pwm_span, pwm_offset;
    logic temp_valid, temp_overrange;
    logic [3:0] tab_addr;
    logic [7:0] tab_span, tab_offset, temp_value;
    logic [8:0] trip;
    int fail_count = 0, checked = 0, n;
    tcc_ctrl #(.CNT_W(8)) dut_u (.clk(clk), .reset_n(reset_n),
        .comp_in(comp_in), .tab_we(tab_we), .tab_addr(tab_addr),
        .tab_span(tab_span), .tab_offset(tab_offset),
        .discharge_out(discharge_out), .pwm_span(pwm_span),
        .pwm_offset(pwm_offset), .temp_valid(temp_valid),
        .temp_value(temp_value), .temp_overrange(temp_overrange));
    tcc_analog_model ana_u (.clk(clk), .discharge_out(discharge_out),
        .trip_cyc(trip), .comp_in(comp_in));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task chk(input string nm, input logic [8:0] e, input logic [8:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask
    task results;
        $display("checks %0d errors %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // one conversion, then one full pwm period measured
    task conv(input logic [8:0] d, input logic ovr);
        int h, s;
        logic [8:0] e;
        n = 0;
        while (!discharge_out && n < 2000) begin @(posedge clk); #1; n++; end
        n = 0;
        while (discharge_out && n < 300) begin @(posedge clk); #1; n++; end
        #1;
        chk("overrange", ovr, temp_overrange);
        if (ovr) chk("temp", 9'h0FF, temp_value);
        else chk("temp_in", 1, temp_value >= d && temp_value <= d + 5);
        e = (temp_value[7:4] == 4'hF) ? 9'h0F0 : temp_value;
        repeat (3) @(posedge clk);
        h = 0;
        s = 0;
        repeat (256) begin @(posedge clk); #1; h += pwm_span; s += pwm_offset; end
        chk("span_duty", e, h[8:0]);
        chk("offset_duty", 9'h0FF - e, s[8:0]);
    endtask
    initial begin
        #60000;
        fail_count++;
        results;
    end
    initial begin
        reset_n = 1'b0;
        tab_we = 1'b0;
        tab_addr = 4'h0;
        tab_span = 8'h00;
        tab_offset = 8'h00;
        trip = 9'd40;
        // calibration points as linear duty ramp
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            tab_we <= 1'b1;
            tab_addr <= i;
            tab_span <= i * 16;
            tab_offset <= 255 - i * 16;
        end
        @(posedge clk) tab_we <= 1'b0;
        @(posedge clk) reset_n <= 1'b1;
        n = 0;
        while (!discharge_out && n < 100) begin @(posedge clk); #1; n++; end
        chk("start_delay", 1, n >= 64 && n <= 68);
        conv(9'd40, 1'b0);
        @(posedge clk) trip <= 9'd200;
        conv(9'd200, 1'b0);
        // never trips: saturates, last entry used
        @(posedge clk) trip <= 9'h1FF;
        conv(9'h1FF, 1'b1);
        @(posedge clk) trip <= 9'd10;
        conv(9'd10, 1'b0);
        results;
    end
endmodule // tcc_ctrl_tb_top
